// File: verilog/fet_drv_cfg.svh
// Constants for the protection transistor driver control.
// Assumes a 50 MHz reference clock.
`ifndef FET_DRV_CFG_SVH
`define FET_DRV_CFG_SVH
`define CLK_PERIOD_NS      20
`define PULLDOWN_TIME_US   100
`define PULLDOWN_CYCLES    ((`PULLDOWN_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PWM_PERIOD_RST     16'h0100
`define PWM_DUTY_RST       16'h0100
`define BODY_THRESH_RST    16'h0064
`endif

// File: verilog/fet_drv_pkg.sv
// Types shared by the transistor driver control.
// Assumes nothing beyond the config header.
`default_nettype none
package fet_drv_pkg;
   // Faults that can block the charge driver
   typedef struct packed {
      logic cellHigh;
      logic hotCharge;
      logic coldCharge;
      logic chargeOvercurrent;
      logic shortCircuit;
      logic diag;
   } chg_faults_t;
   // Faults that can block the discharge driver
   typedef struct packed {
      logic cellLow;
      logic hotDischarge;
      logic coldDischarge;
      logic ocTier1;
      logic ocTier2;
      logic shortCircuit;
      logic diag;
   } dsg_faults_t;
   // PWM settings of one driver
   typedef struct packed {
      logic        enable;
      logic [15:0] period;
      logic [15:0] duty;
   } pwm_cfg_t;
   typedef enum logic [1:0] {CHG_OFF, CHG_PULL, CHG_ON} chg_state_t;
endpackage : fet_drv_pkg
`default_nettype wire

// File: verilog/fet_driver_control.sv
// Charge and discharge protection transistor driver control.
// Assumes all inputs synchronous to ref_clk; pins are resolved outside.
`include "fet_drv_cfg.svh"
`default_nettype none
module fet_driver_control #(
   parameter int PULL_CYCLES = `PULLDOWN_CYCLES
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   // Configuration
   input  wire logic                      seriesMode,
   input  wire logic                      bodyDiodeEn,
   input  wire logic                      forceAllowed,
   input  wire logic [15:0]               bodyThresh,
   input  wire fet_drv_pkg::chg_faults_t  chgSelect,
   input  wire fet_drv_pkg::dsg_faults_t  dsgSelect,
   input  wire logic                      pwmLoad,
   input  wire fet_drv_pkg::pwm_cfg_t     chgPwmIn,
   input  wire fet_drv_pkg::pwm_cfg_t     dsgPwmIn,
   // Host commands, one-cycle pulses
   input  wire logic                      chgBlockSet,
   input  wire logic                      chgBlockClr,
   input  wire logic                      dsgBlockSet,
   input  wire logic                      dsgBlockClr,
   input  wire logic                      chgForceSet,
   input  wire logic                      chgForceClr,
   input  wire logic                      dsgForceSet,
   input  wire logic                      dsgForceClr,
   // Measurements and faults
   input  wire logic signed [15:0]        ccCurrent,
   input  wire logic                      chargerPresent,
   input  wire fet_drv_pkg::chg_faults_t  chgFaults,
   input  wire fet_drv_pkg::dsg_faults_t  dsgFaults,
   // Driver pins
   output logic                           chargeFetDriverHigh,
   output logic                           chargeFetDriverPullLow,
   output logic                           dischargeFetDriver,
   output logic                           dsgOvercurrentEnable,
   output logic                           ovcurrentAllEnable
);
   logic chgBlock_q, dsgBlock_q, chgForce_q, dsgForce_q;
   fet_drv_pkg::pwm_cfg_t chgPwm_q, dsgPwm_q;
   logic [15:0] chgCnt_q, dsgCnt_q;
   logic [31:0] pullCnt_q;
   fet_drv_pkg::chg_state_t chgState_q, chgState_d;
   logic chgFault, dsgFault, charging, discharging, bigCurrent;
   logic bdChg, bdDsg, chgWant, dsgWant, chgPwmOn, dsgPwmOn, chgOn, dsgOn;
   logic [15:0] absCur;

   // Host commands latch until removed; force only when permitted
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chgBlock_q <= 1'b0;
         dsgBlock_q <= 1'b0;
         chgForce_q <= 1'b0;
         dsgForce_q <= 1'b0;
      end else begin
         if (chgBlockSet) chgBlock_q <= 1'b1;
         else if (chgBlockClr) chgBlock_q <= 1'b0;
         if (dsgBlockSet) dsgBlock_q <= 1'b1;
         else if (dsgBlockClr) dsgBlock_q <= 1'b0;
         if (chgForceSet && forceAllowed) chgForce_q <= 1'b1;
         else if (chgForceClr || !forceAllowed) chgForce_q <= 1'b0;
         if (dsgForceSet && forceAllowed) dsgForce_q <= 1'b1;
         else if (dsgForceClr || !forceAllowed) dsgForce_q <= 1'b0;
      end
   end

   // PWM settings storage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chgPwm_q <= {1'b0, `PWM_PERIOD_RST, `PWM_DUTY_RST};
         dsgPwm_q <= {1'b0, `PWM_PERIOD_RST, `PWM_DUTY_RST};
      end else if (pwmLoad) begin
         chgPwm_q <= chgPwmIn;
         dsgPwm_q <= dsgPwmIn;
      end
   end

   // Fault gating and current direction
   always_comb begin
      chgFault    = |(chgFaults & chgSelect);
      dsgFault    = |(dsgFaults & dsgSelect);
      absCur      = ccCurrent[15] ? 16'(-ccCurrent) : ccCurrent;
      bigCurrent  = absCur > bodyThresh;
      charging    = bigCurrent && !ccCurrent[15];
      discharging = bigCurrent && ccCurrent[15];
      chgWant     = (!chgBlock_q && !chgFault) || chgForce_q;
      dsgWant     = (!dsgBlock_q && !dsgFault) || dsgForce_q;
      // Series only, exactly one driver wanted on
      bdDsg = bodyDiodeEn && seriesMode && chgWant && !dsgWant && charging;
      bdChg = bodyDiodeEn && seriesMode && dsgWant && !chgWant && discharging;
   end

   // PWM period counters
   always_ff @(posedge ref_clk) begin
      if (srst || chgCnt_q >= chgPwm_q.period - 16'h0001) chgCnt_q <= 16'h0000;
      else chgCnt_q <= chgCnt_q + 16'h0001;
   end
   always_ff @(posedge ref_clk) begin
      if (srst || dsgCnt_q >= dsgPwm_q.period - 16'h0001) dsgCnt_q <= 16'h0000;
      else dsgCnt_q <= dsgCnt_q + 16'h0001;
   end

   // Faults gate PWM at once since want terms feed the final AND
   always_comb begin
      chgPwmOn = !chgPwm_q.enable || (chgCnt_q < chgPwm_q.duty);
      dsgPwmOn = !dsgPwm_q.enable || (dsgCnt_q < dsgPwm_q.duty);
      chgOn    = (chgWant && chgPwmOn) || bdChg;
      dsgOn    = (dsgWant && dsgPwmOn) || bdDsg;
   end

   // Discharge driver drives both ways; discharge overcurrent enable follows it, all-overcurrent enable tied high
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dischargeFetDriver   <= 1'b0;
         dsgOvercurrentEnable <= 1'b0;
      end else begin
         dischargeFetDriver   <= dsgOn;
         dsgOvercurrentEnable <= dsgOn;
      end
   end
   assign ovcurrentAllEnable = 1'b1;

   // Charge driver turn-off pulldown timer
   always_comb begin
      chgState_d = chgState_q;
      unique case (chgState_q)
         fet_drv_pkg::CHG_OFF:  if (chgOn) chgState_d = fet_drv_pkg::CHG_ON;
         fet_drv_pkg::CHG_ON:   if (!chgOn) chgState_d = fet_drv_pkg::CHG_PULL;
         fet_drv_pkg::CHG_PULL:
            if (chgOn) chgState_d = fet_drv_pkg::CHG_ON;
            else if (pullCnt_q >= 32'(PULL_CYCLES - 1)) chgState_d = fet_drv_pkg::CHG_OFF;
         default: chgState_d = fet_drv_pkg::CHG_OFF; // Unused code falls back to off
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (srst) chgState_q <= fet_drv_pkg::CHG_OFF;
      else chgState_q <= chgState_d;
   end
   // Count only while staying in pulldown, so the count never passes the limit
   always_ff @(posedge ref_clk) begin
      if (srst || chgState_q != fet_drv_pkg::CHG_PULL || chgState_d != fet_drv_pkg::CHG_PULL)
         pullCnt_q <= 32'h0;
      else pullCnt_q <= pullCnt_q + 32'h1;
   end
   // Charger present or not: the high pin drives in on, the low pin pulls down only in pulldown
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chargeFetDriverHigh    <= 1'b0;
         chargeFetDriverPullLow <= 1'b0;
      end else begin
         chargeFetDriverHigh    <= chgState_d == fet_drv_pkg::CHG_ON;
         chargeFetDriverPullLow <= chgState_d == fet_drv_pkg::CHG_PULL;
      end
   end

   // Command, permit and protection checks
   a_force_needs_permit: assert property (@(posedge ref_clk) disable iff (srst)
      !forceAllowed |=> !chgForce_q && !dsgForce_q) else $error("force without permit");
   a_force_dsg_on: assert property (@(posedge ref_clk) disable iff (srst)
      (dsgForce_q && dsgPwmOn) |=> dischargeFetDriver) else $error("dsg force ignored");
   a_block_holds: assert property (@(posedge ref_clk) disable iff (srst)
      chgBlock_q && !chgBlockClr |=> chgBlock_q) else $error("block dropped");
   a_dsg_prot_follow: assert property (@(posedge ref_clk) disable iff (srst)
      dsgOvercurrentEnable == dischargeFetDriver) else $error("protections not following");
   a_oc_always: assert property (@(posedge ref_clk) disable iff (srst)
      ovcurrentAllEnable) else $error("overcurrent disabled");

   // Fault gating checks
   a_dsg_fault_off: assert property (@(posedge ref_clk) disable iff (srst)
      (dsgFault && !dsgForce_q && !bdDsg) |=> !dischargeFetDriver)
      else $error("dsg on under fault");
   a_dsg_free_on: assert property (@(posedge ref_clk) disable iff (srst)
      (!dsgBlock_q && !dsgFault && !dsgPwm_q.enable) |=> dischargeFetDriver)
      else $error("dsg off without cause");
   a_chg_fault_off: assert property (@(posedge ref_clk) disable iff (srst)
      (chgFault && !chgForce_q && !bdChg) |=> !chargeFetDriverHigh)
      else $error("chg on under fault");
   a_chg_free_on: assert property (@(posedge ref_clk) disable iff (srst)
      (!chgBlock_q && !chgFault && !chgPwm_q.enable) |=> chargeFetDriverHigh)
      else $error("chg off without cause");

   // Body-diode checks
   a_bd_series: assert property (@(posedge ref_clk) disable iff (srst)
      (bdChg || bdDsg) |-> seriesMode && bigCurrent) else $error("body diode misuse");
   a_bd_direction: assert property (@(posedge ref_clk) disable iff (srst)
      (bdChg || bdDsg) |-> (bdChg == ccCurrent[15]))
      else $error("body diode wrong direction");

   // Pulldown timer checks
   a_pull_bounded: assert property (@(posedge ref_clk) disable iff (srst)
      pullCnt_q < 32'(PULL_CYCLES)) else $error("pulldown too long");
   a_pull_after_on: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(chargeFetDriverHigh) && !srst |-> chargeFetDriverPullLow)
      else $error("no pulldown on turn off");
   a_pull_release: assert property (@(posedge ref_clk) disable iff (srst)
      (chgState_q == fet_drv_pkg::CHG_PULL && pullCnt_q >= 32'(PULL_CYCLES - 1) && !chgOn)
      |=> !chargeFetDriverPullLow && !chargeFetDriverHigh)
      else $error("pulldown not released");
   a_chg_pins_apart: assert property (@(posedge ref_clk) disable iff (srst)
      !(chargeFetDriverHigh && chargeFetDriverPullLow)) else $error("chg driven both ways");

   // Scenario covers
   c_bd_dsg: cover property (@(posedge ref_clk) bdDsg);
   c_bd_chg: cover property (@(posedge ref_clk) bdChg);
   c_pull_done: cover property (@(posedge ref_clk)
      chgState_q == fet_drv_pkg::CHG_PULL ##1 chgState_q == fet_drv_pkg::CHG_OFF);
   c_dsg_pwm: cover property (@(posedge ref_clk) dsgPwm_q.enable && $fell(dischargeFetDriver));
   c_chg_pwm_charger: cover property (@(posedge ref_clk)
      chargerPresent && chgPwm_q.enable && $rose(chargeFetDriverPullLow));
endmodule : fet_driver_control
`default_nettype wire

// File: dv/fet_gate_model.sv
// Gate levels of the external charge and discharge transistors.
// Assumes driver pins from the driver control block.
`default_nettype none
module fet_gate_model (
   // Driver pins
   input  wire logic chgHigh,
   input  wire logic chgPullLow,
   input  wire logic dsgDrive,
   // Gate levels
   output logic      chgGateOn,
   output logic      dsgGateOn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released gate drains low through its gate-source resistor
   assign chgGateOn = chgHigh & ~chgPullLow;
   // Discharge gate follows the pin, driven both ways
   assign dsgGateOn = dsgDrive;
endmodule : fet_gate_model
`default_nettype wire

// File: dv/tb_protection_fet_driver_control.sv
// Self-checking bench for the transistor driver control.
// Assumes a 50 MHz clock and a shortened pulldown timer.
`default_nettype none
module tb_protection_fet_driver_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULL = 20;
   logic ref_clk = 1'h0, srst = 1'h1, series = 1'h1, bdEn = 1'h0;
   logic forceOk = 1'h0, pwmLoad = 1'h0, charger = 1'h0;
   logic [15:0] thresh = 16'h0064;
   logic signed [15:0] cur = 16'sh0000;
   fet_drv_pkg::chg_faults_t cSel = '1, cFlt = '0;
   fet_drv_pkg::dsg_faults_t dSel = '1, dFlt = '0;
   fet_drv_pkg::pwm_cfg_t cPwm = '0, dPwm = '0;
   logic [7:0] cmd = 8'h00; // Block set/clr chg dsg, then force set/clr chg dsg
   logic cHi, cPull, dDrv, dOc, ocAll, cGate, dGate;
   int error_cnt = 0, n_compared = 0, cnt;
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;
   fet_driver_control #(.PULL_CYCLES(PULL)) dut (.ref_clk(ref_clk), .srst(srst),
      .seriesMode(series), .bodyDiodeEn(bdEn), .forceAllowed(forceOk), .bodyThresh(thresh),
      .chgSelect(cSel), .dsgSelect(dSel), .pwmLoad(pwmLoad), .chgPwmIn(cPwm),
      .dsgPwmIn(dPwm), .chgBlockSet(cmd[7]), .chgBlockClr(cmd[6]), .dsgBlockSet(cmd[5]),
      .dsgBlockClr(cmd[4]), .chgForceSet(cmd[3]), .chgForceClr(cmd[2]),
      .dsgForceSet(cmd[1]), .dsgForceClr(cmd[0]), .ccCurrent(cur),
      .chargerPresent(charger), .chgFaults(cFlt), .dsgFaults(dFlt),
      .chargeFetDriverHigh(cHi), .chargeFetDriverPullLow(cPull), .dischargeFetDriver(dDrv),
      .dsgOvercurrentEnable(dOc), .ovcurrentAllEnable(ocAll));
   fet_gate_model gates (.chgHigh(cHi), .chgPullLow(cPull), .dsgDrive(dDrv),
      .chgGateOn(cGate), .dsgGateOn(dGate));
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic pulse(input logic [7:0] c);
      cmd = c;
      step(1);
      cmd = 8'h00;
      step(2);
   endtask : pulse
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // Counts high cycles of the watched driver over n cycles
   task automatic count(input logic charge_fet_driver, input int n);
      cnt = 0;
      for (int i = 0; i < n; i++) begin
         step(1);
         if ((charge_fet_driver ? cHi : dDrv) === 1'h1) cnt++;
      end
   endtask : count
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      step(12);
      srst = 1'h0;
      step(2);
      check("chg on", cGate, 1'h1);
      check("dsg on", dGate, 1'h1);
      check("dsg oc en", dOc, 1'h1);
      $display("idle test done");
      cmd = 8'h80;
      step(1);
      cmd = 8'h00;
      cnt = 0;
      for (int i = 0; i < 40; i++) begin
         step(1);
         if (cPull === 1'h1) cnt++;
      end
      check("pull cycles", cnt, PULL);
      check("chg released", cHi | cPull, 1'h0);
      check("oc all", ocAll & dOc, 1'h1);
      pulse(8'h08);
      check("force refused", cHi, 1'h0);
      forceOk = 1'h1;
      pulse(8'h08);
      check("force taken", cHi, 1'h1);
      pulse(8'h04);
      pulse(8'h40);
      check("unblocked", cHi, 1'h1);
      $display("command test done");
      for (int i = 0; i < 7; i++) begin
         dFlt = fet_drv_pkg::dsg_faults_t'(7'h01 << i);
         cFlt = fet_drv_pkg::chg_faults_t'(6'h01 << i);
         step(2);
         check("dsg fault", dDrv | dOc, 1'h0);
         check("chg fault", cHi, i == 6);
      end
      cFlt = '0;
      dFlt = '0;
      dFlt.cellLow = 1'h1;
      dSel.cellLow = 1'h0;
      step(2);
      check("unselected", dDrv, 1'h1);
      dSel = '1;
      bdEn = 1'h1;
      cur = 16'sh0065;
      step(2);
      check("diode chg", dDrv, 1'h1);
      cur = 16'sh0064;
      step(2);
      check("at thresh", dDrv, 1'h0);
      cur = 16'shFF9B;
      step(2);
      check("wrong dir", dDrv, 1'h0);
      cur = 16'sh0065;
      series = 1'h0;
      step(2);
      check("parallel", dDrv, 1'h0);
      series = 1'h1;
      dFlt = '0;
      cFlt.cellHigh = 1'h1;
      cur = 16'shFF9B;
      step(2);
      check("diode dsg", cHi, 1'h1);
      bdEn = 1'h0;
      cFlt = '0;
      cur = 16'sh0000;
      $display("body diode test done");
      dFlt.hotDischarge = 1'h1;
      pulse(8'h02);
      check("dsg forced", dDrv, 1'h1);
      pulse(8'h01);
      check("dsg unforced", dDrv, 1'h0);
      dFlt = '0;
      $display("force test done");
      dPwm = {1'h1, 16'h0004, 16'h0002};
      cPwm = dPwm;
      pwmLoad = 1'h1;
      step(1);
      pwmLoad = 1'h0;
      count(1'h0, 8);
      check("dsg pwm", cnt, 4);
      charger = 1'h1;
      count(1'h1, 8);
      check("chg pwm", cnt, 4);
      charger = 1'h0;
      dFlt.ocTier1 = 1'h1;
      step(1);
      count(1'h0, 8);
      check("pwm override", cnt, 0);
      $display("pwm test done");
      conclude();
   end
endmodule : tb_protection_fet_driver_control
`default_nettype wire
